/* File: core/ascv_regs.vh */
// register map, field positions, opcodes and reset values of the command interpreter
`ifndef ASCV_REGS_VH
`define ASCV_REGS_VH

// register word offsets (byte addresses)
`define ASCV_CMD_OFS      8'h00
`define ASCV_LBA_OFS      8'h04
`define ASCV_CNT_OFS      8'h08
`define ASCV_STAT_OFS     8'h0C
`define ASCV_DATA_OFS     8'h10
`define ASCV_IRQ_OFS      8'h14
`define ASCV_MASK_OFS     8'h18
`define ASCV_CTRL_OFS     8'h1C
`define ASCV_ELO_OFS      8'h20
`define ASCV_EHI_OFS      8'h24
`define ASCV_LBAH_OFS     8'h28

// command opcodes
`define ASCV_OP_VERIFY    8'h42
`define ASCV_OP_RECAL_HI  4'h1
`define ASCV_OP_SETPW     8'hF1
`define ASCV_OP_PREP      8'hF3
`define ASCV_OP_ERASE     8'hF4
`define ASCV_OP_FREEZE    8'hF5
`define ASCV_OP_DISPW     8'hF6

// status register fields
`define ASCV_ST_ERR       0
`define ASCV_ST_DRQ       3
`define ASCV_ST_BSY       7
`define ASCV_ST_ABT       8
`define ASCV_ST_FROZEN    9
`define ASCV_ST_LOCKED    10
`define ASCV_ST_USERSET   11
`define ASCV_ST_LVLMAX    12
`define ASCV_ST_ARMED     13

// interrupt status and mask fields
`define ASCV_IRQ_DONE     0
`define ASCV_IRQ_ABORT    1
`define ASCV_IRQ_RST      2'h0

// control register fields and reset value
`define ASCV_CTRL_SEC     0
`define ASCV_CTRL_INJ     1
`define ASCV_CTRL_RST     2'h1

// password sector layout
`define ASCV_PW_ID        0
`define ASCV_PW_LEVEL     8
`define ASCV_PW_FIRST     8'h01
`define ASCV_PW_END       8'h10
`define ASCV_PW_LAST      8'hFF

// bus responses
`define ASCV_RESP_OK      2'h0
`define ASCV_RESP_DEC     2'h3

`endif

/* File: core/ascv_cmd.v */
// task-file command interpreter: 48-bit verify, recalibrate and the security command group
//
// Summary of operation
// - verify sets busy, never raises data request, moves no sector data
// - verify done: busy clears, interrupt raised, address holds last verified sector
// - verify error: stop there, address is failing sector, count holds unverified sectors
// - host writes high address/count bytes first, low second; drive joins both
// - recalibrate, any low nibble, completes without touching stored state
// - disable password takes one sector; matching selected password turns lock mode off
// - disabling keeps master password, which works again after a new user password
// - sector: word 0 bit 0 selects user/master, words 1-16 password, rest reserved
// - erase unit takes one sector and aborts on password mismatch
// - erase unit aborts unless the previous command was a completed erase prepare
// - freeze lock sets frozen; then set, disable and erase are rejected
// - frozen mode only ends at power-on or hardware reset
// - freeze while frozen still succeeds; count reads zero after freeze completes
// - without security support the freeze opcode runs as wear-level command
// - user password, permissive level: lock from next reset, user or master unlocks
// - user password, restrictive level: lock from next reset, only user unlocks
// - master password stored without changing lock mode or security level
`timescale 1ns/1ps
`default_nettype none
`include "ascv_regs.vh"

module ascv_cmd #(
  parameter [255:0] MASTER_PW_INIT = 256'h0  // factory master password, arbitrary value
) (
  input  wire        ref_clk_i,
  input  wire        rst_i,
  input  wire        por_i,
  input  wire [7:0]  s_axi_awaddr_i,
  input  wire        s_axi_awvalid_i,
  output wire        s_axi_awready_o,
  input  wire [31:0] s_axi_wdata_i,
  input  wire [3:0]  s_axi_wstrb_i,
  input  wire        s_axi_wvalid_i,
  output wire        s_axi_wready_o,
  output wire [1:0]  s_axi_bresp_o,
  output wire        s_axi_bvalid_o,
  input  wire        s_axi_bready_i,
  input  wire [7:0]  s_axi_araddr_i,
  input  wire        s_axi_arvalid_i,
  output wire        s_axi_arready_o,
  output wire [31:0] s_axi_rdata_o,
  output wire [1:0]  s_axi_rresp_o,
  output wire        s_axi_rvalid_o,
  input  wire        s_axi_rready_i,
  output wire        irq_o,
  output wire        wear_level_o
);

  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_VERI = 2'h1;
  localparam [1:0] ST_XFER = 2'h2;
  localparam [1:0] ST_EXEC = 2'h3;

  // byte-enable merge for the low word of the error-injection address
  function [31:0] ascv_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  strb;
    integer      k;
    begin
      ascv_merge = old_v;
      for (k = 0; k < 4; k = k + 1) begin
        if (strb[k]) ascv_merge[k*8 +: 8] = new_v[k*8 +: 8];
      end
    end
  endfunction

  // opcodes that carry a password sector and are barred while frozen
  function ascv_is_pw_cmd;
    input [7:0] op;
    begin
      ascv_is_pw_cmd = (op == `ASCV_OP_SETPW) || (op == `ASCV_OP_DISPW) || (op == `ASCV_OP_ERASE);
    end
  endfunction

  reg         aw_got_q;
  reg         w_got_q;
  reg  [7:0]  awa_q;
  reg  [31:0] wd_q;
  reg  [3:0]  ws_q;
  reg         bvalid_q;
  reg  [1:0]  bresp_q;
  reg         rvalid_q;
  reg  [31:0] rdata_q;
  reg  [1:0]  rresp_q;
  reg  [1:0]  irq_q;
  reg  [1:0]  mask_q;
  reg  [1:0]  ctrl_q;
  reg  [47:0] elba_q;
  reg  [1:0]  state_q;
  reg  [7:0]  cmd_q;
  reg  [47:0] lba_q;
  reg  [15:0] cnt_q;
  reg  [16:0] vcnt_q;
  reg         err_q;
  reg         abt_q;
  reg  [7:0]  wcnt_q;
  reg  [255:0] pw_buf_q;
  reg  [15:0] pw_ctl_q;
  reg         frozen_q;
  reg         locked_q;
  reg         armed_q;
  reg         armed_ok_q;
  reg         init_q;
  reg         wear_q;
  reg  [255:0] user_pw_q;
  reg  [255:0] master_pw_q;
  reg         user_set_q;
  reg         level_max_q;

  wire        wr_fire;
  wire        issue;
  wire [15:0] stat_w;
  reg         ex_ok;
  reg         set_user;
  reg         set_master;
  reg         clr_user;
  reg         pw_match;
  reg         done_ev;
  reg         abort_ev;

  ////////////////////////////////////////////////////////////////////////////////
  // bus write side
  assign s_axi_awready_o = !aw_got_q && !bvalid_q;
  assign s_axi_wready_o  = !w_got_q && !bvalid_q;
  assign s_axi_bvalid_o  = bvalid_q;
  assign s_axi_bresp_o   = bresp_q;
  assign wr_fire         = aw_got_q && w_got_q && !bvalid_q;

  // address and data latched independently, response once both are held
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      aw_got_q <= 1'b0;
      w_got_q  <= 1'b0;
      awa_q    <= 8'h00;
      wd_q     <= 32'h0000_0000;
      ws_q     <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q  <= `ASCV_RESP_OK;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_got_q <= 1'b1;
        awa_q    <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_got_q <= 1'b1;
        wd_q    <= s_axi_wdata_i;
        ws_q    <= s_axi_wstrb_i;
      end
      if (wr_fire) begin
        aw_got_q <= 1'b0;
        w_got_q  <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q  <= (awa_q > `ASCV_LBAH_OFS) ? `ASCV_RESP_DEC : `ASCV_RESP_OK;
      end else if (bvalid_q && s_axi_bready_i) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // bus read side
  assign s_axi_arready_o = !rvalid_q;
  assign s_axi_rvalid_o  = rvalid_q;
  assign s_axi_rdata_o   = rdata_q;
  assign s_axi_rresp_o   = rresp_q;

  assign stat_w = {2'h0, armed_q, level_max_q, user_set_q, locked_q, frozen_q, abt_q,
                   (state_q == ST_VERI) || (state_q == ST_EXEC), 3'h0,
                   state_q == ST_XFER, 2'h0, err_q};

  // reads have no side effects; data answered one cycle after the address
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= `ASCV_RESP_OK;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      rvalid_q <= 1'b1;
      rresp_q  <= `ASCV_RESP_OK;
      case ({s_axi_araddr_i[7:2], 2'h0})
        `ASCV_CMD_OFS:  rdata_q <= {24'h0, cmd_q};
        `ASCV_LBA_OFS:  rdata_q <= {8'h0, lba_q[23:0]};
        `ASCV_CNT_OFS:  rdata_q <= {16'h0, cnt_q};
        `ASCV_STAT_OFS: rdata_q <= {16'h0, stat_w};
        `ASCV_DATA_OFS: rdata_q <= 32'h0000_0000;
        `ASCV_IRQ_OFS:  rdata_q <= {30'h0, irq_q};
        `ASCV_MASK_OFS: rdata_q <= {30'h0, mask_q};
        `ASCV_CTRL_OFS: rdata_q <= {30'h0, ctrl_q};
        `ASCV_ELO_OFS:  rdata_q <= elba_q[31:0];
        `ASCV_EHI_OFS:  rdata_q <= {16'h0, elba_q[47:32]};
        `ASCV_LBAH_OFS: rdata_q <= {8'h0, lba_q[47:24]};
        default: begin
          rdata_q <= 32'h0000_0000;
          rresp_q <= `ASCV_RESP_DEC;
        end
      endcase
    end else if (rvalid_q && s_axi_rready_i) begin
      rvalid_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // control, mask, error injection and sticky interrupt status
  assign irq_o = |(irq_q & mask_q);

  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_q  <= `ASCV_IRQ_RST;
      mask_q <= `ASCV_IRQ_RST;
      ctrl_q <= `ASCV_CTRL_RST;
      elba_q <= 48'h0;
    end else begin
      // set wins over a write-one clear in the same cycle
      if (wr_fire && ({awa_q[7:2], 2'h0} == `ASCV_IRQ_OFS))
        irq_q <= (irq_q & ~wd_q[1:0]) | {abort_ev, done_ev};
      else
        irq_q <= irq_q | {abort_ev, done_ev};
      if (wr_fire && ({awa_q[7:2], 2'h0} == `ASCV_MASK_OFS))
        mask_q <= wd_q[1:0];
      if (wr_fire && ({awa_q[7:2], 2'h0} == `ASCV_CTRL_OFS))
        ctrl_q <= wd_q[1:0];
      if (wr_fire && ({awa_q[7:2], 2'h0} == `ASCV_ELO_OFS))
        elba_q[31:0] <= ascv_merge(elba_q[31:0], wd_q, ws_q);
      if (wr_fire && ({awa_q[7:2], 2'h0} == `ASCV_EHI_OFS))
        elba_q[47:32] <= wd_q[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // security decisions taken in the execute cycle
  assign issue = wr_fire && ({awa_q[7:2], 2'h0} == `ASCV_CMD_OFS) && (state_q == ST_IDLE);

  always @* begin
    ex_ok      = 1'b1;
    set_user   = 1'b0;
    set_master = 1'b0;
    clr_user   = 1'b0;
    // master compare refused at the restrictive level
    pw_match   = pw_ctl_q[`ASCV_PW_ID] ? (!level_max_q && pw_buf_q == master_pw_q)
                                       : (pw_buf_q == user_pw_q);
    if (state_q == ST_EXEC) begin
      case (cmd_q)
        `ASCV_OP_SETPW: begin
          ex_ok      = !frozen_q;
          set_master = ex_ok && pw_ctl_q[`ASCV_PW_ID];
          set_user   = ex_ok && !pw_ctl_q[`ASCV_PW_ID];
        end
        `ASCV_OP_DISPW: begin
          ex_ok    = !frozen_q && pw_match;
          clr_user = ex_ok;
        end
        `ASCV_OP_ERASE: begin
          ex_ok    = !frozen_q && armed_ok_q && pw_match;
          clr_user = ex_ok;
        end
        `ASCV_OP_PREP, `ASCV_OP_FREEZE: ex_ok = 1'b1;
        default: ex_ok = (cmd_q[7:4] == `ASCV_OP_RECAL_HI);
      endcase
    end
    done_ev  = ((state_q == ST_EXEC) && ex_ok) ||
               ((state_q == ST_VERI) && (((lba_q == elba_q) && ctrl_q[`ASCV_CTRL_INJ]) || (vcnt_q == 17'h1)));
    abort_ev = (state_q == ST_EXEC) && !ex_ok;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // stored passwords and level survive hardware reset; passwords cleared only at power-on, level also by erase unit
  always @(posedge ref_clk_i or posedge por_i) begin
    if (por_i) begin
      user_pw_q   <= 256'h0;
      master_pw_q <= MASTER_PW_INIT;
      user_set_q  <= 1'b0;
      level_max_q <= 1'b0;
    end else begin
      if (set_user) begin
        user_pw_q   <= pw_buf_q;
        user_set_q  <= 1'b1;
        level_max_q <= pw_ctl_q[`ASCV_PW_LEVEL];
      end
      if (set_master)
        master_pw_q <= pw_buf_q;
      if (clr_user) begin
        user_set_q <= 1'b0;
        if (cmd_q == `ASCV_OP_ERASE)
          level_max_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // command sequencer
  assign wear_level_o = wear_q;

  always @(posedge ref_clk_i or posedge rst_i or posedge por_i) begin
    if (rst_i || por_i) begin
      state_q    <= ST_IDLE;
      cmd_q      <= 8'h00;
      lba_q      <= 48'h0;
      cnt_q      <= 16'h0;
      vcnt_q     <= 17'h0;
      err_q      <= 1'b0;
      abt_q      <= 1'b0;
      wcnt_q     <= 8'h00;
      pw_buf_q   <= 256'h0;
      pw_ctl_q   <= 16'h0;
      frozen_q   <= 1'b0;
      locked_q   <= 1'b0;
      armed_q    <= 1'b0;
      armed_ok_q <= 1'b0;
      init_q     <= 1'b0;
      wear_q     <= 1'b0;
    end else begin
      wear_q <= 1'b0;
      // lock mode taken from the stored password after each reset
      if (!init_q) begin
        init_q   <= 1'b1;
        locked_q <= user_set_q;
      end
      // task-file writes: second write pushes the first into the high half
      if (wr_fire && state_q == ST_IDLE && ({awa_q[7:2], 2'h0} == `ASCV_LBA_OFS))
        lba_q <= {lba_q[23:0], wd_q[23:0]};
      if (wr_fire && state_q == ST_IDLE && ({awa_q[7:2], 2'h0} == `ASCV_CNT_OFS))
        cnt_q <= {cnt_q[7:0], wd_q[7:0]};
      case (state_q)
        ST_IDLE: begin
          if (issue) begin
            cmd_q      <= wd_q[7:0];
            err_q      <= 1'b0;
            abt_q      <= 1'b0;
            armed_ok_q <= armed_q;
            armed_q    <= 1'b0;
            wcnt_q     <= 8'h00;
            vcnt_q     <= {cnt_q == 16'h0, cnt_q};
            if (wd_q[7:0] == `ASCV_OP_VERIFY)
              state_q <= ST_VERI;
            else if (ascv_is_pw_cmd(wd_q[7:0]) && ctrl_q[`ASCV_CTRL_SEC])
              state_q <= ST_XFER;
            else
              state_q <= ST_EXEC;
          end
        end
        ST_VERI: begin
          if (ctrl_q[`ASCV_CTRL_INJ] && lba_q == elba_q) begin
            err_q   <= 1'b1;
            cnt_q   <= vcnt_q[15:0];
            state_q <= ST_IDLE;
          end else if (vcnt_q == 17'h1) begin
            state_q <= ST_IDLE;
          end else begin
            lba_q  <= lba_q + 48'h1;
            vcnt_q <= vcnt_q - 17'h1;
          end
        end
        ST_XFER: begin
          // one 16-bit word per data write; reserved words are dropped
          if (wr_fire && ({awa_q[7:2], 2'h0} == `ASCV_DATA_OFS)) begin
            wcnt_q <= wcnt_q + 8'h01;
            if (wcnt_q == 8'h00)
              pw_ctl_q <= wd_q[15:0];
            if (wcnt_q >= `ASCV_PW_FIRST && wcnt_q <= `ASCV_PW_END)
              pw_buf_q <= {wd_q[15:0], pw_buf_q[255:16]};
            if (wcnt_q == `ASCV_PW_LAST)
              state_q <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          state_q <= ST_IDLE;
          if (!ex_ok) begin
            err_q <= 1'b1;
            abt_q <= 1'b1;
          end
          if (cmd_q == `ASCV_OP_PREP)
            armed_q <= 1'b1;
          if (clr_user)
            locked_q <= 1'b0;
          if (cmd_q == `ASCV_OP_FREEZE) begin
            if (ctrl_q[`ASCV_CTRL_SEC]) begin
              frozen_q <= 1'b1;
              cnt_q    <= 16'h0;
            end else begin
              wear_q <= 1'b1;
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

endmodule // ascv_cmd

`default_nettype wire

/* File: verif/ascv_cmd_chk.sv */
// port assertions for the command interpreter, bound to its top module
`timescale 1ns/1ps
`default_nettype none
`include "ascv_regs.vh"
module ascv_cmd_chk (
  input wire logic        ref_clk_i,
  input wire logic        rst_i,
  input wire logic        por_i,
  input wire logic [7:0]  s_axi_awaddr_i,
  input wire logic        s_axi_awvalid_i,
  input wire logic        s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic        s_axi_wvalid_i,
  input wire logic        s_axi_wready_o,
  input wire logic [1:0]  s_axi_bresp_o,
  input wire logic        s_axi_bvalid_o,
  input wire logic [7:0]  s_axi_araddr_i,
  input wire logic        s_axi_arvalid_i,
  input wire logic        s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [1:0]  s_axi_rresp_o,
  input wire logic        s_axi_rvalid_o,
  input wire logic        wear_level_o
);
  logic [7:0] op_q;
  logic [7:0] ra_q;
  logic       frz_q;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i || por_i);
  ////////////////////////////////////////////////////////////
  sequence s_wr_hs;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  endsequence
  sequence s_rd_hs;
    s_axi_arvalid_i && s_axi_arready_o;
  endsequence
  // last opcode, last read address, frozen once reported
  always @(posedge ref_clk_i or posedge rst_i or posedge por_i) begin
    if (rst_i || por_i) begin
      op_q <= 8'h00;
      ra_q <= 8'h00;
      frz_q <= 1'b0;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o && s_axi_awaddr_i == `ASCV_CMD_OFS) op_q <= s_axi_wdata_i[7:0];
      if (s_axi_arvalid_i && s_axi_arready_o) ra_q <= s_axi_araddr_i;
      if (s_axi_rvalid_o && ra_q == `ASCV_STAT_OFS && s_axi_rdata_o[`ASCV_ST_FROZEN]) frz_q <= 1'b1;
    end
  end
  a_write_answer: assert property (s_wr_hs |=> ##1 s_axi_bvalid_o) else $error("write answer late");
  a_read_answer: assert property (s_rd_hs |=> s_axi_rvalid_o) else $error("read answer late");
  a_resp_blocks: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
    else $error("write taken while answering");
  a_unmapped_read: assert property (s_rd_hs ##0 s_axi_araddr_i[7:2] > 6'h0A |=>
    s_axi_rresp_o == `ASCV_RESP_DEC && s_axi_rdata_o == 32'h0) else $error("unmapped read answered");
  a_verify_no_drq: assert property (s_axi_rvalid_o && ra_q == `ASCV_STAT_OFS && op_q == `ASCV_OP_VERIFY |->
    !s_axi_rdata_o[`ASCV_ST_DRQ]) else $error("data request during verify");
  a_frozen_kept: assert property (s_axi_rvalid_o && ra_q == `ASCV_STAT_OFS && frz_q |->
    s_axi_rdata_o[`ASCV_ST_FROZEN]) else $error("frozen mode left");
  a_wear_pulse: assert property (wear_level_o |=> !wear_level_o) else $error("wear pulse too long");
  a_wear_cause: assert property (wear_level_o |-> op_q == `ASCV_OP_FREEZE) else $error("wear pulse uncaused");
endmodule // ascv_cmd_chk
bind ascv_cmd ascv_cmd_chk u_chk (.ref_clk_i, .rst_i, .por_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o,
  .s_axi_wdata_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_araddr_i,
  .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .wear_level_o);
`default_nettype wire

/* File: verif/ascv_host.sv */
// host controller model: bus master cycles and password sector transfer
`timescale 1ns/1ps
`default_nettype none
`include "ascv_regs.vh"
module ascv_host (
  input  wire logic        ref_clk_i,
  output var  logic [7:0]  s_axi_awaddr_i,
  output var  logic        s_axi_awvalid_i,
  input  wire logic        s_axi_awready_o,
  output var  logic [31:0] s_axi_wdata_i,
  output var  logic [3:0]  s_axi_wstrb_i,
  output var  logic        s_axi_wvalid_i,
  input  wire logic        s_axi_wready_o,
  input  wire logic [1:0]  s_axi_bresp_o,
  input  wire logic        s_axi_bvalid_o,
  output var  logic        s_axi_bready_i,
  output var  logic [7:0]  s_axi_araddr_i,
  output var  logic        s_axi_arvalid_i,
  input  wire logic        s_axi_arready_o,
  input  wire logic [31:0] s_axi_rdata_o,
  input  wire logic [1:0]  s_axi_rresp_o,
  input  wire logic        s_axi_rvalid_o,
  output var  logic        s_axi_rready_i
);
  // bus idle at time zero
  initial begin
    {s_axi_awaddr_i, s_axi_awvalid_i, s_axi_wdata_i, s_axi_wvalid_i, s_axi_bready_i} = '0;
    {s_axi_araddr_i, s_axi_arvalid_i, s_axi_rready_i} = '0;
    s_axi_wstrb_i = 4'hF;
  end
  ////////////////////////////////////////////////////////////
  // one write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
    @(posedge ref_clk_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= v;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
    end while (!s_axi_bvalid_o);
    r = s_axi_bresp_o;
    s_axi_bready_i <= 1'b0;
  endtask
  // one read, data taken at the edge where it is valid
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    @(posedge ref_clk_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
    end while (!s_axi_rvalid_o);
    v = s_axi_rdata_o;
    r = s_axi_rresp_o;
    s_axi_rready_i <= 1'b0;
  endtask
  // password sector: control word, sixteen password words, reserved zeros
  task automatic sector(input logic [15:0] c, input logic [15:0] p);
    logic [1:0] r;
    for (int i = 0; i < 256; i++) wr(`ASCV_DATA_OFS, {16'h0, (i == 0) ? c : ((i <= 16) ? p : 16'h0)}, r);
  endtask
  // address and count, high-order part first
  task automatic lba48(input logic [47:0] a, input logic [15:0] n);
    logic [1:0] r;
    wr(`ASCV_LBA_OFS, {8'h0, a[47:24]}, r);
    wr(`ASCV_LBA_OFS, {8'h0, a[23:0]}, r);
    wr(`ASCV_CNT_OFS, {24'h0, n[15:8]}, r);
    wr(`ASCV_CNT_OFS, {24'h0, n[7:0]}, r);
  endtask
endmodule // ascv_host
`default_nettype wire

/* File: verif/tb_top.sv */
// self-checking bench for the command interpreter
`timescale 1ns/1ps
`default_nettype none
`include "ascv_regs.vh"
module tb_top;
  logic        ref_clk_i, rst_i, por_i, irq_o, wear_level_o, s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i;
  logic        s_axi_wready_o, s_axi_bvalid_o, s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o;
  logic        s_axi_rready_i;
  logic [7:0]  s_axi_awaddr_i, s_axi_araddr_i;
  logic [31:0] s_axi_wdata_i, s_axi_rdata_o, d;
  logic [3:0]  s_axi_wstrb_i;
  logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, r;
  int          err_count, checks, wear_n;
  bit          inj;
  ascv_cmd dut (.ref_clk_i, .rst_i, .por_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i,
    .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
    .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o,
    .s_axi_rready_i, .irq_o, .wear_level_o);
  ascv_host host (.ref_clk_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i,
    .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i,
    .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i);
  ////////////////////////////////////////////////////////////
  // 50 ns clock
  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end
  // count wear-level pulses
  always @(posedge ref_clk_i) begin
    if (wear_level_o === 1'b1) wear_n <= wear_n + 1;
  end
  task automatic ck(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic rg(input logic [7:0] a);
    host.rd(a, d, r);
  endtask
  task automatic w(input logic [7:0] a, input logic [31:0] v);
    host.wr(a, v, r);
  endtask
  task automatic hw_reset();
    rst_i <= 1'b1;
    @(posedge ref_clk_i);
    rst_i <= 1'b0;
  endtask
  // issue a command, feed a sector when asked, poll to the end, check abort report
  task automatic run(input logic [7:0] op, input logic [15:0] c, input logic [15:0] p, input logic a);
    w(`ASCV_CMD_OFS, {24'h0, op});
    rg(`ASCV_STAT_OFS);
    if (op == `ASCV_OP_VERIFY) ck(d[`ASCV_ST_BSY], 1'b1);
    if (d[`ASCV_ST_DRQ]) host.sector(c, p);
    repeat (60) begin
      if (op == `ASCV_OP_VERIFY) ck(d[`ASCV_ST_DRQ], 1'b0);
      if (d[`ASCV_ST_BSY] | d[`ASCV_ST_DRQ]) rg(`ASCV_STAT_OFS);
    end
    ck({d[`ASCV_ST_ABT], d[`ASCV_ST_ERR]}, {a, a | inj});
  endtask
  task automatic t_reset();
    rg(`ASCV_CTRL_OFS);
    ck(d, 32'h1);
    rg(8'h2C);
    ck(r, `ASCV_RESP_DEC);
    ck(d, 32'h0);
    w(8'h40, 32'h1);
    ck(r, `ASCV_RESP_DEC);
    $display("reset and map done");
  endtask
  task automatic t_verify();
    host.lba48(48'h000001000010, 16'd40);
    run(`ASCV_OP_VERIFY, 16'h0, 16'h0, 1'b0);
    rg(`ASCV_LBAH_OFS);
    ck(d, 32'h1);
    rg(`ASCV_LBA_OFS);
    ck(d, 32'h37);
    ck(irq_o, 1'b0);
    w(`ASCV_MASK_OFS, 32'h1);
    @(negedge ref_clk_i);
    ck(irq_o, 1'b1);
    w(`ASCV_IRQ_OFS, 32'h1);
    @(negedge ref_clk_i);
    ck(irq_o, 1'b0);
    w(`ASCV_CTRL_OFS, 32'h3);
    w(`ASCV_ELO_OFS, 32'h01000012);
    w(`ASCV_EHI_OFS, 32'h0);
    inj = 1'b1;
    host.lba48(48'h000001000010, 16'd40);
    run(`ASCV_OP_VERIFY, 16'h0, 16'h0, 1'b0);
    ck(d[`ASCV_ST_ERR], 1'b1);
    rg(`ASCV_LBA_OFS);
    ck(d, 32'h12);
    rg(`ASCV_CNT_OFS);
    ck(d, 32'd38);
    w(`ASCV_CTRL_OFS, 32'h1);
    inj = 1'b0;
    $display("verify done");
  endtask
  task automatic t_recal();
    for (int i = 16; i < 32; i++) run(i[7:0], 16'h0, 16'h0, 1'b0);
    rg(`ASCV_CNT_OFS);
    ck(d, 32'd38);
    run(8'h00, 16'h0, 16'h0, 1'b1);
    run(`ASCV_OP_ERASE, 16'h0, 16'h0, 1'b1);
    rg(`ASCV_IRQ_OFS);
    ck(d[`ASCV_IRQ_ABORT], 1'b1);
    run(`ASCV_OP_PREP, 16'h0, 16'h0, 1'b0);
    run(8'h10, 16'h0, 16'h0, 1'b0);
    run(`ASCV_OP_ERASE, 16'h0, 16'h0, 1'b1);
    $display("recalibrate and arming done");
  endtask
  task automatic t_passwords();
    run(`ASCV_OP_SETPW, 16'h0, 16'hA5A5, 1'b0);
    ck(d[12:10], 3'b010);
    hw_reset();
    rg(`ASCV_STAT_OFS);
    ck(d[12:10], 3'b011);
    run(`ASCV_OP_SETPW, 16'h1, 16'h3C3C, 1'b0);
    ck(d[12:10], 3'b011);
    run(`ASCV_OP_PREP, 16'h0, 16'h0, 1'b0);
    run(`ASCV_OP_ERASE, 16'h0, 16'h1111, 1'b1);
    run(`ASCV_OP_PREP, 16'h0, 16'h0, 1'b0);
    run(`ASCV_OP_ERASE, 16'h0, 16'hA5A5, 1'b0);
    ck(d[`ASCV_ST_LOCKED], 1'b0);
    run(`ASCV_OP_SETPW, 16'h0100, 16'h7777, 1'b0);
    ck(d[`ASCV_ST_LVLMAX], 1'b1);
    hw_reset();
    run(`ASCV_OP_DISPW, 16'h1, 16'h3C3C, 1'b1);
    run(`ASCV_OP_DISPW, 16'h0, 16'h7777, 1'b0);
    ck(d[`ASCV_ST_LOCKED], 1'b0);
    run(`ASCV_OP_SETPW, 16'h0, 16'h2222, 1'b0);
    hw_reset();
    run(`ASCV_OP_DISPW, 16'h1, 16'h3C3C, 1'b0);
    ck(d[11:10], 2'b00);
    $display("password commands done");
  endtask
  task automatic t_freeze();
    host.lba48(48'h0, 16'd5);
    run(`ASCV_OP_FREEZE, 16'h0, 16'h0, 1'b0);
    ck(d[`ASCV_ST_FROZEN], 1'b1);
    rg(`ASCV_CNT_OFS);
    ck(d, 32'h0);
    host.lba48(48'h0, 16'd5);
    run(`ASCV_OP_FREEZE, 16'h0, 16'h0, 1'b0);
    rg(`ASCV_CNT_OFS);
    ck(d, 32'h0);
    run(`ASCV_OP_SETPW, 16'h0, 16'h1234, 1'b1);
    run(`ASCV_OP_DISPW, 16'h1, 16'h3C3C, 1'b1);
    run(`ASCV_OP_PREP, 16'h0, 16'h0, 1'b0);
    run(`ASCV_OP_ERASE, 16'h1, 16'h3C3C, 1'b1);
    run(8'h1F, 16'h0, 16'h0, 1'b0);
    ck(d[`ASCV_ST_FROZEN], 1'b1);
    ck(wear_n, 32'h0);
    hw_reset();
    rg(`ASCV_STAT_OFS);
    ck(d[`ASCV_ST_FROZEN], 1'b0);
    w(`ASCV_CTRL_OFS, 32'h0);
    run(`ASCV_OP_FREEZE, 16'h0, 16'h0, 1'b0);
    ck(wear_n, 32'h1);
    ck(d[`ASCV_ST_FROZEN], 1'b0);
    $display("freeze done");
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // main sequence
  initial begin
    {err_count, checks, wear_n} = '0;
    rst_i = 1'b1;
    por_i = 1'b1;
    repeat (20) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    por_i <= 1'b0;
    t_reset();
    t_verify();
    t_recal();
    t_passwords();
    t_freeze();
    test_done();
  end
  // watchdog
  initial begin
    repeat (60000) @(posedge ref_clk_i);
    err_count++;
    test_done();
  end
endmodule // tb_top
`default_nettype wire
